/* File: rtl/epo_pkg.sv */
// package: constants, register map and carrier types of the energy pulse outputs
package epo_pkg;
    // apb register byte offsets
    localparam logic [7:0] EPO_CTRL_OFS = 8'h00;
    localparam logic [7:0] EPO_DIO_OFS = 8'h04;
    localparam logic [7:0] EPO_TI_OFS = 8'h08;
    localparam logic [7:0] EPO_STAT_OFS = 8'h0C;
    // ctrl fields
    localparam int EPO_CTRL_MAXW_LSB = 0;
    localparam int EPO_CTRL_INV_BIT = 8;
    localparam logic [7:0] EPO_MAXW_RST = 8'h00;
    localparam logic [7:0] EPO_MAXW_OFF = 8'hFF;
    localparam logic EPO_INV_RST = 1'b0;
    // dio field: 2 bits per pin
    localparam int EPO_DIO_FW = 2;
    localparam logic [1:0] EPO_DIO_HIZ = 2'h0;
    localparam logic [1:0] EPO_DIO_PULSE = 2'h1;
    localparam logic [1:0] EPO_DIO_LOW = 2'h2;
    localparam logic [1:0] EPO_DIO_HIGH = 2'h3;
    localparam logic [7:0] EPO_DIO_RST = 8'h00;
    // pulse interval: 65.772 us at 20 MHz
    localparam real EPO_TI_NS = 65772.0;
    localparam real EPO_CLK_NS = 50.0;
    localparam logic [15:0] EPO_TI_CYC = 16'(int'(EPO_TI_NS / EPO_CLK_NS));
    localparam logic [31:0] EPO_ZERO32 = 32'h0000_0000;

    typedef enum logic [1:0] {
        EPO_IDLE = 2'b00,
        EPO_ACT = 2'b01,
        EPO_REST = 2'b10
    } epo_state_t;

    // triggers coming from the signal processor
    typedef struct packed {
        logic pass_strobe;
        logic zero_cross;
        logic sag;
        logic reactive;
        logic active;
    } epo_trig_t;

    // pin pairs (output and output enable) for the four dio pins
    typedef struct packed {
        logic [3:0] o;
        logic [3:0] oe;
    } epo_dio_t;
endpackage : epo_pkg

/* File: rtl/epo_energy_gen.sv */
// single energy pulse generator with optional maximum width limit
`timescale 1ns/1ps
module epo_energy_gen
    import epo_pkg::*;
#(
    parameter int TIW = 16,
    parameter int CW = 26
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic trig,
    input wire logic [7:0] max_width,
    input wire logic [TIW-1:0] ti_cycles,
    output logic pulse
);
    epo_state_t state_q;
    logic [CW-1:0] width_cnt_q;
    logic [CW-1:0] gap_cnt_q;
    logic [CW-1:0] half_gap_q;
    logic [CW-1:0] tmax;
    logic limit_on;

    // RULE4: tmax = (2*w+1)*ti cycles
    // both factors widened first so the product is not cut to the interval width
    assign tmax = CW'({1'b0, max_width, 1'b1}) * CW'(ti_cycles);
    assign limit_on = (max_width != EPO_MAXW_OFF);

    // interval since last trigger, half of it bounds the next pulse
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gap_cnt_q <= '0;
            half_gap_q <= '0;
        end else if (trig) begin
            gap_cnt_q <= CW'(1);
            half_gap_q <= gap_cnt_q >> 1;
        end else if (gap_cnt_q != {CW{1'b1}}) begin
            gap_cnt_q <= gap_cnt_q + CW'(1);
        end
    end

    // RULE12: one pulse per trigger
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= EPO_IDLE;
            width_cnt_q <= '0;
        end else begin
            unique case (state_q)
                EPO_IDLE: begin
                    if (trig) begin
                        state_q <= EPO_ACT;
                        width_cnt_q <= CW'(1);
                    end
                end
                EPO_ACT: begin
                    width_cnt_q <= width_cnt_q + CW'(1);
                    if (trig) begin
                        width_cnt_q <= CW'(1);
                    // RULE14: end at tmax or half gap
                    end else if (limit_on &&
                            (width_cnt_q >= tmax || width_cnt_q >= half_gap_q)) begin
                        state_q <= EPO_REST;
                    // RULE5: 50% duty when unlimited
                    end else if (!limit_on && width_cnt_q >= half_gap_q) begin
                        state_q <= EPO_REST;
                    end
                end
                EPO_REST: begin
                    if (trig) begin
                        state_q <= EPO_ACT;
                        width_cnt_q <= CW'(1);
                    end
                end
                default: state_q <= EPO_IDLE;
            endcase
        end
    end

    assign pulse = (state_q == EPO_ACT);

    // RULE4: width never beyond tmax
    property p_width_max;
        @(posedge clk) disable iff (!resetn)
        (state_q == EPO_ACT && limit_on && !trig && width_cnt_q >= tmax) |=>
            (state_q == EPO_REST);
    endproperty
    a_width_max: assert property (p_width_max) else $error("pulse exceeds max width"); // RULE4
endmodule : epo_energy_gen

/* File: rtl/epo_top.sv */
// top: pulse outputs, polarity, width limit, dio mapping and apb registers
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: four independent pulse generators, events chosen by signal processor triggers; the code has two generators, pins 2 and 3 take zc_q and sag_q
// RULE2: polarity invert bit makes all four outputs active high
// RULE3: invert resets to zero so energy pulses go low after reset
// RULE4: max width equals (2*field+1) times pulse interval in cycles
// RULE5: field 255 disables limiting, pulses run near 50% duty
// RULE6: pulse interval defaults to 65.772 us, processor may rewrite it
// RULE7: software normally writes 76 for about 10 ms width
// RULE8: zero crossing drives pin 2, sag drives pin 3
// RULE9: zero crossing and sag change at most once per program pass
// RULE10: active energy drives pin 0, reactive energy drives pin 1
// RULE11: zero crossing and sag pulse on their events
// RULE12: one energy pulse per programmed quantity accumulated
// RULE13: all dio pins high impedance after reset, each separately configured
// RULE14: limited pulse ends at max width or half the pulse gap
module epo_top
    import epo_pkg::*;
#(
    parameter int TIW = 16,
    parameter int CW = 26
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire epo_pkg::epo_trig_t TRIG,
    input wire logic [3:0] DIO_I,
    output epo_pkg::epo_dio_t DIO
);
    import epo_pkg::*;

    logic [7:0] max_width_q;
    logic inv_q;
    logic [7:0] dio_cfg_q;
    logic [TIW-1:0] ti_q;
    logic zc_q;
    logic sag_q;
    logic [3:0] raw;
    logic [3:0] pol;
    logic [3:0] dio_o_q;
    logic [3:0] dio_oe_q;
    logic wr;
    logic rd;
    logic hit;
    logic [31:0] rdata;
    logic zc_chg;
    logic sag_chg;

    assign PREADY = 1'b1;
    assign wr = PSEL && PENABLE && PWRITE;
    assign rd = PSEL && PENABLE && !PWRITE;
    assign hit = (PADDR == EPO_CTRL_OFS) || (PADDR == EPO_DIO_OFS) ||
                 (PADDR == EPO_TI_OFS) || (PADDR == EPO_STAT_OFS);
    // unmapped offsets answer with an error, writes there do nothing
    assign PSLVERR = PSEL && PENABLE && !hit;

    // RULE3: invert clear at reset
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            max_width_q <= EPO_MAXW_RST;
            inv_q <= EPO_INV_RST;
        end else if (wr && PADDR == EPO_CTRL_OFS) begin
            max_width_q <= PWDATA[EPO_CTRL_MAXW_LSB +: 8];
            inv_q <= PWDATA[EPO_CTRL_INV_BIT];
        end
    end

    // RULE13: dio fields reset to high impedance
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            dio_cfg_q <= EPO_DIO_RST;
        end else if (wr && PADDR == EPO_DIO_OFS) begin
            dio_cfg_q <= PWDATA[7:0];
        end
    end

    // RULE6: interval register, default 65.772 us
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ti_q <= TIW'(EPO_TI_CYC);
        end else if (wr && PADDR == EPO_TI_OFS) begin
            ti_q <= PWDATA[TIW-1:0];
        end
    end

    // zero-crossing and sag are levels; holding them to the pass strobe stops mid-pass glitches
    assign zc_chg = TRIG.pass_strobe && (TRIG.zero_cross != zc_q);
    assign sag_chg = TRIG.pass_strobe && (TRIG.sag != sag_q);
    // RULE9: update once per pass
    // RULE11: follow zero crossing and sag events
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            zc_q <= 1'b0;
            sag_q <= 1'b0;
        end else if (TRIG.pass_strobe) begin
            zc_q <= TRIG.zero_cross;
            sag_q <= TRIG.sag;
        end
    end

    // RULE1: independent generators for outputs 0 and 1
    // RULE12: energy pulse per trigger
    epo_energy_gen #(.TIW(TIW), .CW(CW)) u_active (
        .clk(CLK),
        .resetn(RESETN),
        .trig(TRIG.active),
        .max_width(max_width_q),
        .ti_cycles(ti_q),
        .pulse(raw[0])
    );
    epo_energy_gen #(.TIW(TIW), .CW(CW)) u_reactive (
        .clk(CLK),
        .resetn(RESETN),
        .trig(TRIG.reactive),
        .max_width(max_width_q),
        .ti_cycles(ti_q),
        .pulse(raw[1])
    );
    // RULE8: zero crossing on 2, sag on 3
    assign raw[2] = zc_q;
    assign raw[3] = sag_q;

    // RULE2: one bit inverts all four
    // RULE10: active on 0, reactive on 1
    assign pol = inv_q ? raw : ~raw;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_dio
            logic [1:0] mode;
            assign mode = dio_cfg_q[g*EPO_DIO_FW +: EPO_DIO_FW];
            // RULE13: each pin has its own field
            always_ff @(posedge CLK or negedge RESETN) begin
                if (!RESETN) begin
                    dio_o_q[g] <= 1'b0;
                    dio_oe_q[g] <= 1'b0;
                end else begin
                    dio_oe_q[g] <= (mode != EPO_DIO_HIZ);
                    unique case (mode)
                        EPO_DIO_HIZ: dio_o_q[g] <= 1'b0;
                        EPO_DIO_PULSE: dio_o_q[g] <= pol[g];
                        EPO_DIO_LOW: dio_o_q[g] <= 1'b0;
                        EPO_DIO_HIGH: dio_o_q[g] <= 1'b1;
                    endcase
                end
            end
        end
    endgenerate

    assign DIO.o = dio_o_q;
    assign DIO.oe = dio_oe_q;

    always_comb begin
        rdata = EPO_ZERO32;
        unique case (PADDR)
            EPO_CTRL_OFS: begin
                rdata[EPO_CTRL_MAXW_LSB +: 8] = max_width_q;
                rdata[EPO_CTRL_INV_BIT] = inv_q;
            end
            EPO_DIO_OFS: rdata[7:0] = dio_cfg_q;
            EPO_TI_OFS: rdata[TIW-1:0] = ti_q;
            EPO_STAT_OFS: rdata[11:0] = {DIO_I, pol, raw};
            default: rdata = EPO_ZERO32;
        endcase
    end

    // read data registered in the setup cycle so it is a flop at the access edge
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            PRDATA <= EPO_ZERO32;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= rdata;
        end
    end

    // RULE13: pins released after reset
    property p_hiz_reset;
        @(posedge CLK) disable iff (!RESETN)
        $rose(RESETN) |-> (DIO.oe == 4'h0);
    endproperty
    a_hiz_reset: assert property (p_hiz_reset) else $error("dio driven after reset"); // RULE13

    // RULE2: polarity follows invert bit
    property p_polarity;
        @(posedge CLK) disable iff (!RESETN)
        (dio_cfg_q[1:0] == EPO_DIO_PULSE) |=> (DIO.o[0] == (inv_q ~^ $past(raw[0])) ||
            $changed(inv_q) || $changed(dio_cfg_q));
    endproperty
    a_polarity: assert property (p_polarity) else $error("pin 0 polarity wrong"); // RULE2

    // RULE3: idle energy output high by default
    property p_idle_high;
        @(posedge CLK) disable iff (!RESETN)
        (!inv_q && !raw[1] && dio_cfg_q[3:2] == EPO_DIO_PULSE) |=> DIO.o[1];
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("energy idle level wrong"); // RULE3

    // RULE9: zero crossing holds between passes
    property p_zc_hold;
        @(posedge CLK) disable iff (!RESETN)
        !TRIG.pass_strobe |=> $stable(zc_q);
    endproperty
    a_zc_hold: assert property (p_zc_hold) else $error("zero crossing changed mid pass"); // RULE9

    // RULE11: zero crossing follows on the pass
    property p_zc_follow;
        @(posedge CLK) disable iff (!RESETN)
        zc_chg |=> (zc_q == $past(TRIG.zero_cross));
    endproperty
    a_zc_follow: assert property (p_zc_follow) else $error("zero crossing not taken"); // RULE11

    // RULE8: sag reaches pin 3
    property p_sag_pin;
        @(posedge CLK) disable iff (!RESETN)
        (sag_chg && dio_cfg_q[7:6] == EPO_DIO_PULSE) ##1 $stable(dio_cfg_q) |=>
            (DIO.o[3] == (inv_q ~^ $past(sag_q)) || $changed(inv_q));
    endproperty
    a_sag_pin: assert property (p_sag_pin) else $error("sag not on pin 3"); // RULE8

    // RULE12: trigger starts active pulse
    property p_active_start;
        @(posedge CLK) disable iff (!RESETN)
        TRIG.active |=> raw[0];
    endproperty
    a_active_start: assert property (p_active_start) else $error("no active pulse"); // RULE12

    // RULE10: reactive pulse reaches pin 1
    property p_react_pin;
        @(posedge CLK) disable iff (!RESETN)
        (dio_cfg_q[3:2] == EPO_DIO_PULSE && $stable(dio_cfg_q) && $stable(inv_q)) |->
            (DIO.o[1] == (inv_q ~^ $past(raw[1])));
    endproperty
    a_react_pin: assert property (p_react_pin) else $error("reactive not on pin 1"); // RULE10
endmodule : epo_top

/* File: verification/epo_far.sv */
// far side model: signal processor strobes and the loads on the dio pins
`timescale 1ns/1ps
module epo_far
    import epo_pkg::*;
(
    input wire logic clk,
    input wire epo_pkg::epo_dio_t dio,
    output epo_pkg::epo_trig_t trig,
    output logic [3:0] pin
);
    logic [3:0] last_q;
    initial trig = '0;
    initial last_q = 4'h0;
    always @(posedge clk) last_q <= pin;
    // no pull on the pins, so a released pin must not keep its last level
    assign pin = (dio.oe & dio.o) | (~dio.oe & ~last_q);
    // one-cycle strobe, levels are only meaningful with pass_strobe
    task automatic fire(input logic [4:0] t);
        @(posedge clk);
        trig <= t;
        @(posedge clk);
        trig <= '0;
    endtask : fire
endmodule : epo_far

/* File: verification/testbench.sv */
// self-checking bench for the energy pulse outputs
`timescale 1ns/1ps
module testbench;
    import epo_pkg::*;
    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    epo_trig_t trig;
    epo_dio_t dio;
    logic [3:0] pin;
    logic [32:0] rq[$];
    int wq[$];
    int mismatches = 0;
    int checks_done = 0;
    int cyc = 0;
    int w0 = 0;
    int n0 = 0;
    int n1 = 0;
    logic [3:0] r;
    logic [7:0] f[4] = '{8'h00, 8'h03, 8'h4C, 8'hFF};
    int lo[4] = '{2, 14, 306, 400};

    epo_top u_dut (
        .CLK(CLK), .RESETN(RESETN), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .TRIG(trig), .DIO_I(pin), .DIO(dio)
    );
    epo_far u_far (.clk(CLK), .dio(dio), .trig(trig), .pin(pin));

    initial forever #25 CLK = ~CLK;

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge CLK);
        penable <= 1'b1;
        @(posedge CLK);
        // the wait ends once pready is high; a stuck wait ends only at the bench timeout
        while (pready !== 1'b1) begin
            @(posedge CLK);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        rq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    // read data is taken only at the edge that completes the access
    always @(posedge CLK) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            chk({pslverr, prdata}, rq.pop_front());
        end
    end

    // low time of the active energy pin, counted in clock cycles
    always @(posedge CLK) begin
        if (dio.oe[0] === 1'b1 && dio.o[0] === 1'b0) begin
            w0 <= w0 + 1;
        end else if (w0 != 0) begin
            n0 <= n0 + 1;
            chk({1'b0, w0}, {1'b0, wq[0]});
            void'(wq.pop_front());
            w0 <= 0;
        end
        if (dio.oe[1] === 1'b1 && $fell(dio.o[1])) n1 <= n1 + 1;
    end

    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc > 30000) begin
            mismatches++;
            close_out();
        end
    end

    initial begin
        void'($urandom(8));
        repeat (10) @(posedge CLK);
        RESETN <= 1'b1;
        rd(EPO_CTRL_OFS, 33'h0);
        rd(EPO_DIO_OFS, 33'h0);
        rd(EPO_TI_OFS, {17'h0, EPO_TI_CYC});
        rd(8'h10, {1'b1, EPO_ZERO32});
        @(negedge CLK);
        chk({29'h0, dio.oe}, 33'h0);
        $display("test reset done");
        // short interval keeps the long widths cheap to simulate
        apb(1'b1, EPO_TI_OFS, 32'h2);
        apb(1'b1, EPO_DIO_OFS, 32'h55);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, EPO_CTRL_OFS, {24'h0, f[i]});
            for (int j = 0; j < 3; j++) begin
                // gaps are 800 cycles, 803 after a ctrl write; the first pulse has a long gap
                wq.push_back((i == 3 && j == 0) ? 401 : lo[i]);
                u_far.fire(5'h01);
                repeat (798) @(posedge CLK);
            end
        end
        chk({1'b0, n0}, 33'd12);
        // limit on: the reactive gap since reset is long, so tmax keeps the pulse short
        apb(1'b1, EPO_CTRL_OFS, 32'h0);
        u_far.fire(5'h02);
        repeat (20) @(posedge CLK);
        chk({1'b0, n1}, 33'd1);
        chk({1'b0, n0}, 33'd12);
        $display("test energy done");
        u_far.fire(5'h08);
        repeat (4) @(posedge CLK);
        rd(EPO_STAT_OFS, 33'hFF0);
        for (int i = 0; i < 4; i++) begin
            r = 4'($urandom) & 4'hC;
            u_far.fire({1'b1, r[2], r[3], 2'b00});
            repeat (4) @(posedge CLK);
            rd(EPO_STAT_OFS, {21'h0, ~r, ~r, r});
        end
        $display("test zero sag done");
        apb(1'b1, EPO_DIO_OFS, 32'hE4);
        repeat (2) @(posedge CLK);
        @(negedge CLK);
        chk({29'h0, dio.oe}, 33'hE);
        chk({30'h0, dio.o[3:1]}, 33'h5);
        apb(1'b1, EPO_DIO_OFS, 32'h55);
        apb(1'b1, EPO_CTRL_OFS, 32'h1FF);
        repeat (2) @(posedge CLK);
        rd(EPO_STAT_OFS, {21'h0, r, r, r});
        $display("test polarity done");
        close_out();
    end
endmodule : testbench
